/* design/spr_pulse_receiver.sv */
// Purpose: single wire pulse receiver driving five led sink channels
// Assumes: 10 MHz clock, pin synchronous, avalon-mm slave for status
// Notes:   configuration arrives only over the pulse pin
//
// How it works
// RULE1: the pulse pin alone enables, disables and writes every setting.
// RULE2: host holds pin high 1 ms after shutdown before pulsing.
// RULE3: the wakeup high time is only demanded when leaving shutdown.
// RULE4: host keeps pulses and gaps between 0.75 us and 250 us.
// RULE5: first burst latched as address after 550 us high hold.
// RULE6: second burst latched as data after 550 us high hold.
// RULE7: pin high 12 ms resets bus state, dropping partial transfers.
// RULE8: pin high over 10 ms puts bus logic into standby.
// RULE9: pin low 10 ms shuts the device down, all functions off.
// RULE10: five sink channels, each with a 0 to 25 mA setting.
// RULE11: channels map onto up to three banks with independent currents.
// RULE12: all sinks stay off after power-up until enabled.
// RULE13: high pulses per burst are counted to form the field value.
// RULE14: a 100 ns time base measures pulse, gap and hold lengths.
module spr_pulse_receiver #(
  parameter logic [spr_pkg::TIMER_W-1:0] WAKEUP_CYC    = spr_pkg::WAKEUP_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] HOLD1_MIN_CYC = spr_pkg::HOLD1_MIN_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] HOLD1_MAX_CYC = spr_pkg::HOLD1_MAX_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] HOLD2_MIN_CYC = spr_pkg::HOLD2_MIN_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] STANDBY_CYC   = spr_pkg::STANDBY_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] BUS_RESET_CYC = spr_pkg::BUS_RESET_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] SHUTDOWN_CYC  = spr_pkg::SHUTDOWN_CYC
) (
  input  wire logic                 i_sys_clk,               // 10 MHz clock
  input  wire logic                 i_rst_n,                 // sync reset, low
  input  wire logic                 i_pulse_control_pin,     // single wire input
  input  wire logic [4:0]           i_avs_address,           // byte address
  input  wire logic                 i_avs_read,              // read request
  input  wire logic                 i_avs_write,             // write request
  input  wire logic [31:0]          i_avs_writedata,         // write data
  output logic      [31:0]          o_avs_readdata,          // read data
  output logic                      o_avs_waitrequest,       // stall
  output spr_pkg::spr_sink_t [spr_pkg::NUM_SINKS-1:0] o_sinks, // per channel
  output logic                      o_device_on              // not shut down
);

  localparam int TW = spr_pkg::TIMER_W;
  localparam int FW = spr_pkg::FIELD_W;
  localparam int LW = spr_pkg::LEVEL_W;
  localparam int NS = spr_pkg::NUM_SINKS;
  localparam int NB = spr_pkg::NUM_BANKS;
  localparam int BW = spr_pkg::BANK_SEL_W;

  logic          lvl;
  logic [TW-1:0] cnt;

  // ---------------------------------------------------------------
  // pin time base
  // ---------------------------------------------------------------
  spr_level_timer #(.W(TW)) u_timer ( // RULE14
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_pulse_control_pin),
    .o_level   (lvl),
    .o_count   (cnt)
  );

  // ---------------------------------------------------------------
  // pulse decoder and configuration state
  // ---------------------------------------------------------------
  spr_pkg::spr_state_t          state_reg, state_next;
  logic                         idx_reg, idx_next;
  logic [FW-1:0]                pulses_reg, pulses_next;
  spr_pkg::spr_field_t          field_reg, field_next;
  logic [NS-1:0]                enable_reg, enable_next;
  logic [NB-1:0][LW-1:0]        bank_reg, bank_next;
  logic [NS-1:0][BW-1:0]        group_reg, group_next;
  logic [spr_pkg::FLAG_W-1:0]   flags_reg, flags_next;
  logic                         long_reg, long_next;
  logic                         short_reg, short_next;
  logic [spr_pkg::FLAG_W-1:0]   flag_set;
  logic [spr_pkg::FLAG_W-1:0]   flag_clr;
  logic                         fall;
  logic                         do_write;
  logic [FW-1:0]                grp_idx;

  assign fall    = !lvl && (cnt == TW'(1));
  assign grp_idx = field_next.addr - spr_pkg::FADDR_GROUP0;

  // software clears flags by writing ones; a same-cycle set still wins
  assign flag_clr = (i_avs_write && i_avs_address == spr_pkg::REG_FLAGS) ?
                    i_avs_writedata[spr_pkg::FLAG_W-1:0] : '0;

  // next state of the decoder, its fields and the sink settings
  always_comb begin
    state_next  = state_reg;
    idx_next    = idx_reg;
    pulses_next = pulses_reg;
    field_next  = field_reg;
    enable_next = enable_reg;
    bank_next   = bank_reg;
    group_next  = group_reg;
    flag_set    = '0;
    do_write    = 1'b0;
    // remember whether the high just ended was out of range
    long_next   = lvl && (cnt > spr_pkg::PULSE_MAX_CYC);
    short_next  = lvl && (cnt < spr_pkg::PULSE_MIN_CYC);

    unique case (state_reg)
      spr_pkg::ST_SHUTDOWN: begin
        if (lvl && cnt == WAKEUP_CYC) begin // RULE3
          state_next = spr_pkg::ST_STANDBY;
        end
      end
      spr_pkg::ST_STANDBY: begin
        if (fall) begin
          state_next  = spr_pkg::ST_BURST;
          idx_next    = 1'b0;
          pulses_next = '0;
        end
      end
      spr_pkg::ST_BURST: begin
        if (fall) begin
          pulses_next = (pulses_reg == '1) ? pulses_reg : pulses_reg + FW'(1); // RULE13
          if (long_reg || short_reg) begin
            flag_set[spr_pkg::FLAG_TIMING] = 1'b1; // RULE4
          end
        end else if (!lvl && cnt == spr_pkg::PULSE_MAX_CYC + TW'(1)) begin
          flag_set[spr_pkg::FLAG_TIMING] = 1'b1; // RULE4
        end else if (lvl && !idx_reg && cnt == HOLD1_MIN_CYC) begin
          field_next.addr = pulses_reg; // RULE5
          idx_next        = 1'b1;
          pulses_next     = '0;
          state_next      = spr_pkg::ST_FIELD_WAIT;
        end else if (lvl && idx_reg && cnt == HOLD2_MIN_CYC) begin
          field_next.data = pulses_reg; // RULE6
          do_write        = 1'b1;
          state_next      = spr_pkg::ST_STANDBY;
        end
      end
      spr_pkg::ST_FIELD_WAIT: begin
        if (fall) begin
          state_next = spr_pkg::ST_BURST;
        end else if (lvl && cnt == HOLD1_MAX_CYC + TW'(1)) begin
          flag_set[spr_pkg::FLAG_HOLD] = 1'b1; // RULE5
        end
      end
    endcase

    // decoded write lands in the sink settings
    if (do_write) begin // RULE1
      flag_set[spr_pkg::FLAG_WRITE] = 1'b1;
      if (field_next.addr == spr_pkg::FADDR_ENABLE) begin
        enable_next = field_next.data[NS-1:0]; // RULE12
      end else if (field_next.addr >= spr_pkg::FADDR_BANK0 &&
                   field_next.addr < spr_pkg::FADDR_GROUP0) begin
        bank_next[field_next.addr - spr_pkg::FADDR_BANK0] = field_next.data[LW-1:0]; // RULE10
      end else if (field_next.addr >= spr_pkg::FADDR_GROUP0 &&
                   grp_idx < FW'(NS) && field_next.data < FW'(NB)) begin
        group_next[grp_idx] = field_next.data[BW-1:0]; // RULE11
      end
    end

    // long highs: standby past 10 ms, bus reset at 12 ms
    if (lvl && state_reg != spr_pkg::ST_SHUTDOWN) begin
      if (cnt == STANDBY_CYC + TW'(1)) begin
        state_next  = spr_pkg::ST_STANDBY; // RULE8
        pulses_next = '0;
      end
      if (cnt == BUS_RESET_CYC) begin
        state_next  = spr_pkg::ST_STANDBY; // RULE7
        idx_next    = 1'b0;
        pulses_next = '0;
        flag_set[spr_pkg::FLAG_BUSRST] = 1'b1;
      end
    end

    // long low: shut down and drop every setting
    if (!lvl && cnt == SHUTDOWN_CYC && state_reg != spr_pkg::ST_SHUTDOWN) begin
      state_next  = spr_pkg::ST_SHUTDOWN; // RULE9
      idx_next    = 1'b0;
      pulses_next = '0;
      enable_next = spr_pkg::ENABLE_RST;
      bank_next   = '0;
      group_next  = '0;
      flag_set[spr_pkg::FLAG_SHUTDOWN] = 1'b1;
    end

    flags_next = (flags_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg  <= spr_pkg::ST_SHUTDOWN;
      idx_reg    <= 1'b0;
      pulses_reg <= '0;
      field_reg  <= '0;
      enable_reg <= spr_pkg::ENABLE_RST; // RULE12
      bank_reg   <= '0;
      group_reg  <= '0;
      flags_reg  <= '0;
      long_reg   <= 1'b0;
      short_reg  <= 1'b0;
    end else begin
      state_reg  <= state_next;
      idx_reg    <= idx_next;
      pulses_reg <= pulses_next;
      field_reg  <= field_next;
      enable_reg <= enable_next;
      bank_reg   <= bank_next;
      group_reg  <= group_next;
      flags_reg  <= flags_next;
      long_reg   <= long_next;
      short_reg  <= short_next;
    end
  end

  // ---------------------------------------------------------------
  // sink outputs, one per channel
  // ---------------------------------------------------------------
  assign o_device_on = (state_reg != spr_pkg::ST_SHUTDOWN); // RULE9

  for (genvar g = 0; g < NS; g++) begin : g_sink
    // a zero level also turns the channel off
    assign o_sinks[g].level = bank_reg[group_reg[g]]; // RULE11
    assign o_sinks[g].on    = enable_reg[g] && o_device_on &&
                              (bank_reg[group_reg[g]] != spr_pkg::LEVEL_RST); // RULE10
  end

  // ---------------------------------------------------------------
  // avalon-mm slave: reads take one wait cycle, writes none
  // ---------------------------------------------------------------
  logic        rd_ack_reg, rd_ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] rd_mux;

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      spr_pkg::REG_STATUS: rd_mux = {16'h0000, pulses_reg, 5'h00, idx_reg, state_reg};
      spr_pkg::REG_FLAGS:  rd_mux = {27'h0000000, flags_reg};
      spr_pkg::REG_FIELDS: rd_mux = {16'h0000, field_reg};
      spr_pkg::REG_ENABLE: rd_mux = {27'h0000000, enable_reg};
      spr_pkg::REG_BANKS:  rd_mux = {8'h00, 2'b00, bank_reg[2], 2'b00, bank_reg[1],
                                     2'b00, bank_reg[0]};
      spr_pkg::REG_GROUP:  rd_mux = {22'h000000, group_reg};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // registered read data keeps the data output off the mux
  always_comb begin
    rd_ack_next = i_avs_read && !rd_ack_reg;
    rdata_next  = (i_avs_read && !rd_ack_reg) ? rd_mux : rdata_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      rd_ack_reg <= rd_ack_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign o_avs_waitrequest = i_avs_read && !rd_ack_reg;
  assign o_avs_readdata    = rdata_reg;

endmodule

/* include/spr_pkg.sv */
// Purpose: shared constants and types for the single wire pulse receiver
// Assumes: 10 MHz system clock, pulse pin already synchronous to it
// Notes:   every time is held in its own unit and converted to cycles here
package spr_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_PER_US    = 1000 / CLK_PERIOD_NS;
  localparam int TIMER_W       = 18;
  localparam int FIELD_W       = 8;
  localparam int NUM_SINKS     = 5;
  localparam int NUM_BANKS     = 3;
  localparam int LEVEL_W       = 6;
  localparam int BANK_SEL_W    = 2;

  // pin timing in printed units
  localparam int WAKEUP_HIGH_TIME_MS       = 1;
  localparam int PULSE_MIN_WIDTH_NS        = 750;
  localparam int PULSE_MAX_WIDTH_US        = 250;
  localparam int FIRST_FIELD_HOLD_MIN_US   = 550;
  localparam int FIRST_FIELD_HOLD_MAX_US   = 5000;
  localparam int SECOND_FIELD_HOLD_MIN_US  = 550;
  localparam int STANDBY_HIGH_TIME_MS      = 10;
  localparam int BUS_RESET_TIME_MS         = 12;
  localparam int SHUTDOWN_LOW_TIME_MS      = 10;

  // cycle counts: least times round up, longest times round down
  localparam logic [TIMER_W-1:0] WAKEUP_CYC =
    TIMER_W'(WAKEUP_HIGH_TIME_MS * 1000 * CLK_PER_US);
  localparam logic [TIMER_W-1:0] PULSE_MIN_CYC =
    TIMER_W'((PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] PULSE_MAX_CYC =
    TIMER_W'(PULSE_MAX_WIDTH_US * CLK_PER_US);
  localparam logic [TIMER_W-1:0] HOLD1_MIN_CYC =
    TIMER_W'(FIRST_FIELD_HOLD_MIN_US * CLK_PER_US);
  localparam logic [TIMER_W-1:0] HOLD1_MAX_CYC =
    TIMER_W'(FIRST_FIELD_HOLD_MAX_US * CLK_PER_US);
  localparam logic [TIMER_W-1:0] HOLD2_MIN_CYC =
    TIMER_W'(SECOND_FIELD_HOLD_MIN_US * CLK_PER_US);
  localparam logic [TIMER_W-1:0] STANDBY_CYC =
    TIMER_W'(STANDBY_HIGH_TIME_MS * 1000 * CLK_PER_US);
  localparam logic [TIMER_W-1:0] BUS_RESET_CYC =
    TIMER_W'(BUS_RESET_TIME_MS * 1000 * CLK_PER_US);
  localparam logic [TIMER_W-1:0] SHUTDOWN_CYC =
    TIMER_W'(SHUTDOWN_LOW_TIME_MS * 1000 * CLK_PER_US);

  // ---------------------------------------------------------------
  // register map (byte addresses on the avalon slave)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_FLAGS  = 5'h04;
  localparam logic [4:0] REG_FIELDS = 5'h08;
  localparam logic [4:0] REG_ENABLE = 5'h0C;
  localparam logic [4:0] REG_BANKS  = 5'h10;
  localparam logic [4:0] REG_GROUP  = 5'h14;

  // flag bit positions in REG_FLAGS
  localparam int FLAG_TIMING   = 0;
  localparam int FLAG_HOLD     = 1;
  localparam int FLAG_BUSRST   = 2;
  localparam int FLAG_SHUTDOWN = 3;
  localparam int FLAG_WRITE    = 4;
  localparam int FLAG_W        = 5;

  // pulse-written address map
  localparam logic [FIELD_W-1:0] FADDR_ENABLE = 8'h00;
  localparam logic [FIELD_W-1:0] FADDR_BANK0  = 8'h01;
  localparam logic [FIELD_W-1:0] FADDR_GROUP0 = 8'h04;

  // reset values
  localparam logic [NUM_SINKS-1:0] ENABLE_RST = 5'h00;
  localparam logic [LEVEL_W-1:0]   LEVEL_RST  = 6'h00;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_STANDBY,
    ST_BURST,
    ST_FIELD_WAIT
  } spr_state_t;

  typedef struct packed {
    logic               on;
    logic [LEVEL_W-1:0] level;
  } spr_sink_t;

  typedef struct packed {
    logic [FIELD_W-1:0] addr;
    logic [FIELD_W-1:0] data;
  } spr_field_t;

endpackage

/* design/spr_level_timer.sv */
// Purpose: measures how long the pulse pin has held its present level
// Assumes: pin synchronous to the clock
// Notes:   count saturates, so very long levels stay comparable
module spr_level_timer #(
  parameter int W = 18
) (
  input  wire logic         i_sys_clk, // system clock
  input  wire logic         i_rst_n,   // sync reset, active low
  input  wire logic         i_pin,     // pulse control pin
  output logic              o_level,   // registered pin level
  output logic [W-1:0]      o_count    // cycles at this level, from 1
);

  logic         lvl_reg;
  logic         lvl_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ---------------------------------------------------------------
  // free-running time base, restarted on every level change
  // ---------------------------------------------------------------
  always_comb begin
    lvl_next = i_pin;
    if (i_pin != lvl_reg) begin
      cnt_next = W'(1);
    end else if (cnt_reg == '1) begin
      cnt_next = cnt_reg; // hold at top rather than wrap
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lvl_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      lvl_reg <= lvl_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_level = lvl_reg;
  assign o_count = cnt_reg;

endmodule

/* test/spr_pulse_checker.sv */
// Purpose: concurrent checks on the pulse receiver ports
// Assumes: bound into every spr_pulse_receiver, one clock domain
// Notes:   pin timer lags the pin, so level thresholds carry slack
module spr_pulse_checker #(
  parameter logic [spr_pkg::TIMER_W-1:0] WAKEUP_CYC    = spr_pkg::WAKEUP_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] HOLD2_MIN_CYC = spr_pkg::HOLD2_MIN_CYC,
  parameter logic [spr_pkg::TIMER_W-1:0] SHUTDOWN_CYC  = spr_pkg::SHUTDOWN_CYC
) (
  input wire logic                                    i_sys_clk,           // clock
  input wire logic                                    i_rst_n,             // sync reset
  input wire logic                                    i_pulse_control_pin, // pin
  input wire logic                                    i_avs_read,          // read
  input wire logic                                    i_avs_write,         // write
  input wire logic                                    o_avs_waitrequest,   // stall
  input wire spr_pkg::spr_sink_t [spr_pkg::NUM_SINKS-1:0] o_sinks,         // sinks
  input wire logic                                    o_device_on          // awake
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // run lengths of the pin level
  // ---------------------------------------------------------------
  logic [spr_pkg::TIMER_W-1:0]   hi_reg;
  logic [spr_pkg::TIMER_W-1:0]   hi_next;
  logic [spr_pkg::TIMER_W-1:0]   lo_reg;
  logic [spr_pkg::TIMER_W-1:0]   lo_next;
  logic [spr_pkg::NUM_SINKS-1:0] on_bits;
  // saturate so a long level never wraps back to a short one
  always_comb begin
    hi_next = i_pulse_control_pin ? hi_reg + spr_pkg::TIMER_W'(~&hi_reg) : '0;
    lo_next = !i_pulse_control_pin ? lo_reg + spr_pkg::TIMER_W'(~&lo_reg) : '0;
    for (int i = 0; i < spr_pkg::NUM_SINKS; i++) begin
      on_bits[i] = o_sinks[i].on;
    end
  end
  // register the run lengths
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      hi_reg <= '0;
      lo_reg <= '0;
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  a_read_one_wait: assert property ($rose(i_avs_read) |-> s_one_wait)
    else $error("read not answered after one wait");
  a_write_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write stalled");
  a_off_sinks_dark: assert property (!o_device_on |-> on_bits == '0)
    else $error("sink on while shut down");
  a_low_shuts_down: assert property (lo_reg >= SHUTDOWN_CYC + 4 |-> !o_device_on)
    else $error("long low did not shut down");
  a_wake_after_high: assert property ($rose(o_device_on) |-> hi_reg >= WAKEUP_CYC)
    else $error("woke before high time");
  a_wake_on_time: assert property (hi_reg >= WAKEUP_CYC + 4 |-> o_device_on)
    else $error("long high did not wake");
  a_set_by_hold: assert property (o_device_on && $past(o_device_on) && $changed(o_sinks)
    |-> hi_reg >= HOLD2_MIN_CYC)
    else $error("sinks changed without data hold");
  a_reset_dark: assert property (disable iff (1'b0)
    !i_rst_n |=> !o_device_on && on_bits == '0)
    else $error("not dark after reset");
  for (genvar g = 0; g < spr_pkg::NUM_SINKS; g++) begin : g_lv
    a_on_has_level: assert property (o_sinks[g].on |-> o_sinks[g].level != '0)
      else $error("sink on with zero level");
  end
endmodule
bind spr_pulse_receiver spr_pulse_checker #(
  .WAKEUP_CYC    (WAKEUP_CYC),
  .HOLD2_MIN_CYC (HOLD2_MIN_CYC),
  .SHUTDOWN_CYC  (SHUTDOWN_CYC)
) u_chk (
  .i_sys_clk           (i_sys_clk),
  .i_rst_n             (i_rst_n),
  .i_pulse_control_pin (i_pulse_control_pin),
  .i_avs_read          (i_avs_read),
  .i_avs_write         (i_avs_write),
  .o_avs_waitrequest   (o_avs_waitrequest),
  .o_sinks             (o_sinks),
  .o_device_on         (o_device_on)
);

/* test/spr_host_model.sv */
// Purpose: host side of the single wire, drives timed pulse bursts
// Assumes: 100 ns clock, pulses of 10 cycles
// Notes:   pin changes only just after a rising edge
module spr_host_model (
  input  wire logic i_sys_clk, // system clock
  output logic      o_pin      // pulse control pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // pulse tasks
  // ---------------------------------------------------------------
  localparam int PULSE_CYC = 10; // 1 us, inside the legal width
  initial o_pin = 1'b0;
  // hold a level for n cycles from the next edge
  task automatic level(input logic v, input int n);
    @(posedge i_sys_clk);
    o_pin <= v;
    repeat (n - 1) @(posedge i_sys_clk);
  endtask
  // opening fall, n high pulses, then a long high hold
  task automatic burst(input int n, input int hold);
    level(1'b0, PULSE_CYC);
    repeat (n) begin
      level(1'b1, PULSE_CYC);
      level(1'b0, PULSE_CYC);
    end
    level(1'b1, hold);
  endtask
  // whole transfer: address burst then data burst
  task automatic send(input int a, input int d, input int hold);
    burst(a, hold);
    burst(d, hold);
  endtask
endmodule

/* test/tb_top.sv */
// Purpose: self-checking bench for the single wire pulse receiver
// Assumes: shortened timing parameters, host model on the pin
// Notes:   avalon side reads registers, clears flags and tries one enable write, so settings come by pulses
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
    $display("BAD %s exp %0h got %0h", n, e, a); num_errors++; end end
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam int HOLD = 40; // past the 30 cycle latch, below the 60 limit
  // shortened pin times keep the whole run to a few thousand cycles
  localparam logic [spr_pkg::TIMER_W-1:0] T_WAKE = 18'h28;
  localparam logic [spr_pkg::TIMER_W-1:0] T_HOLD = 18'h1E;
  localparam logic [spr_pkg::TIMER_W-1:0] T_HMAX = 18'h3C;
  localparam logic [spr_pkg::TIMER_W-1:0] T_LONG = 18'h64;
  localparam logic [spr_pkg::TIMER_W-1:0] T_BRST = 18'h78;
  logic                                      sys_clk;
  logic                                      rst_n;
  logic                                      pin;
  logic [4:0]                                av_addr;
  logic                                      av_rd;
  logic                                      av_wr;
  logic [31:0]                               av_wdata;
  logic [31:0]                               av_rdata;
  logic                                      av_wait;
  spr_pkg::spr_sink_t [spr_pkg::NUM_SINKS-1:0] sinks;
  logic                                      dev_on;
  int                                        num_errors;
  int                                        num_checks;
  spr_host_model u_host (.i_sys_clk(sys_clk), .o_pin(pin));
  spr_pulse_receiver #(
    .WAKEUP_CYC(T_WAKE), .HOLD1_MIN_CYC(T_HOLD), .HOLD1_MAX_CYC(T_HMAX),
    .HOLD2_MIN_CYC(T_HOLD), .STANDBY_CYC(T_LONG), .BUS_RESET_CYC(T_BRST),
    .SHUTDOWN_CYC(T_LONG)
  ) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_pulse_control_pin(pin),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait), .o_sinks(sinks), .o_device_on(dev_on)
  );
  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // bus and closing tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic xfer(input logic r, input logic [4:0] a, input logic [31:0] w,
                      output logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    av_rd <= r;
    av_wr <= !r;
    av_addr <= a;
    av_wdata <= w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (av_wait !== 1'b0 && n < 20);
    d = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (av_wait !== 1'b0) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    xfer(1'b1, a, 32'h0, d);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] w);
    logic [31:0] x;
    xfer(1'b0, a, w, x);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_after_reset;
    logic [31:0] d;
    rd(spr_pkg::REG_STATUS, d);
    `CHK("state", 2'h0, d[1:0])
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("flags", 32'h0, d)
    rd(5'h18, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("sinks", 35'h0, sinks)
  endtask
  // pulses while shut down are ignored; wake needs the full high time
  task automatic t_wake;
    logic [31:0] d;
    u_host.burst(2, 20);
    u_host.level(1'b0, 20);
    `CHK("off_pulse", 1'b0, dev_on)
    u_host.level(1'b1, 30);
    @(negedge sys_clk);
    `CHK("early", 1'b0, dev_on)
    u_host.level(1'b1, 20);
    @(negedge sys_clk);
    `CHK("awake", 1'b1, dev_on)
    rd(spr_pkg::REG_STATUS, d);
    `CHK("standby", 2'h1, d[1:0])
  endtask
  // zero-pulse address, back to back transfers, bus cannot configure
  task automatic t_write_all;
    logic [31:0] d;
    u_host.send(0, 31, HOLD);
    u_host.send(1, 7, HOLD);
    rd(spr_pkg::REG_FIELDS, d);
    `CHK("fields", 16'h0107, d[15:0])
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("wdone", 1'b1, d[spr_pkg::FLAG_WRITE])
    wr(spr_pkg::REG_FLAGS, 32'h1F);
    wr(spr_pkg::REG_ENABLE, 32'h0);
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("wclear", 1'b0, d[spr_pkg::FLAG_WRITE])
    for (int i = 0; i < spr_pkg::NUM_SINKS; i++) begin
      `CHK("on", 1'b1, sinks[i].on)
      `CHK("level", 6'h07, sinks[i].level)
    end
  endtask
  // channel 2 moved to its own bank with its own current
  task automatic t_bank_split;
    u_host.send(2, 3, HOLD);
    u_host.send(5, 1, HOLD);
    `CHK("ch1", 6'h07, sinks[0].level)
    `CHK("ch2", 6'h03, sinks[1].level)
    `CHK("ch3", 6'h07, sinks[2].level)
  endtask
  // address only, then long high: standby first, bus reset later
  task automatic t_bus_reset;
    logic [31:0] d;
    wr(spr_pkg::REG_FLAGS, 32'h1F);
    // opening fall, then one 300 ns pulse, too short to be legal
    u_host.level(1'b0, 10);
    u_host.level(1'b1, 3);
    u_host.level(1'b0, 10);
    u_host.level(1'b1, HOLD);
    repeat (65) @(posedge sys_clk);
    rd(spr_pkg::REG_STATUS, d);
    `CHK("stby", 2'h1, d[1:0])
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("no_brst", 1'b0, d[spr_pkg::FLAG_BUSRST])
    `CHK("short", 1'b1, d[spr_pkg::FLAG_TIMING])
    `CHK("late", 1'b1, d[spr_pkg::FLAG_HOLD])
    repeat (20) @(posedge sys_clk);
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("brst", 1'b1, d[spr_pkg::FLAG_BUSRST])
    u_host.send(2, 4, HOLD);
    `CHK("kept", 6'h07, sinks[0].level)
    `CHK("new", 6'h04, sinks[1].level)
  endtask
  // long low shuts down and clears; waking again leaves sinks dark
  task automatic t_shutdown;
    logic [31:0] d;
    u_host.level(1'b0, 90);
    @(negedge sys_clk);
    `CHK("still_on", 1'b1, dev_on)
    u_host.level(1'b0, 20);
    @(negedge sys_clk);
    `CHK("off", 1'b0, dev_on)
    `CHK("dark", 35'h0, sinks)
    rd(spr_pkg::REG_FLAGS, d);
    `CHK("sd_flag", 1'b1, d[spr_pkg::FLAG_SHUTDOWN])
    u_host.level(1'b1, 50);
    @(negedge sys_clk);
    `CHK("rewake", 1'b1, dev_on)
    `CHK("cleared", 35'h0, sinks)
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    av_addr = 5'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_after_reset();
    t_wake();
    t_write_all();
    t_bank_split();
    t_bus_reset();
    t_shutdown();
    summarize();
  end
endmodule
